// ==== core/tthc_host_ctrl.sv ====
// host register port and transmit control of a dual-tone transceiver
// assumes a microcontroller bus on pins, a receiver block on the same clock
// delivering validated digits and steering, and a comparator output for call progress
`timescale 1ns/100ps
`include "tthc_defs.svh"
module tthc_host_ctrl
	import tthc_pkg::*;
#(
	parameter logic [`TTHC_CNT_W-1:0] BURST_CYCLES = `TTHC_CNT_W'(`TTHC_BURST_CYCLES),
	parameter logic [`TTHC_CNT_W-1:0] BURST_CP_CYCLES = `TTHC_CNT_W'(`TTHC_BURST_CP_CYCLES)
) (
	// clock, reset, enable
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// host bus pins
	input wire logic i_cs_n,
	input wire logic i_register_class_select,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	input wire logic [`TTHC_DATA_W-1:0] i_data,
	output logic [`TTHC_DATA_W-1:0] o_data,
	output logic o_data_oe_n,
	// shared interrupt or call progress pin, open drain
	input wire logic i_interrupt_tone_pin,
	output logic o_interrupt_tone_pin,
	output logic o_interrupt_tone_pin_oe_n,
	// receiver side
	input wire logic i_rx_digit_valid,
	input wire logic [`TTHC_DATA_W-1:0] i_rx_digit_code,
	input wire logic i_delayed_steer,
	input wire logic i_call_progress_square,
	output logic o_rx_enable,
	// tone generator side
	output logic [`TTHC_DATA_W-1:0] o_tone_code,
	output logic o_tone_on,
	output logic o_single_tone,
	output logic o_column_group
);
	logic rst_meta_n;
	logic rst_n;
	tthc_bus_s bus_pin;
	tthc_bus_s bus_s;
	logic [`TTHC_DATA_W-1:0] data_s;
	logic cp_square_s;
	tthc_state_s st;
	tthc_state_s next_st;

	// ==========================================================
	// reset release
	// a low enable also holds the release, so the whole block wakes together
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else if (i_clk_en) begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// pin synchronisers
	assign bus_pin = '{cs_n: i_cs_n, register_class_select: i_register_class_select,
		wr_n: i_wr_n, rd_n: i_rd_n};

	tthc_sync3 #(.W(`TTHC_PIN_W)) u_sync_bus (
		.i_clock(i_clock),
		.i_rst_n(rst_n),
		.i_clk_en(i_clk_en),
		.i_pin(bus_pin),
		.o_value(bus_s)
	);

	// data goes through the same filter as the strobes, so both line up
	tthc_sync3 #(.W(`TTHC_DATA_W)) u_sync_data (
		.i_clock(i_clock),
		.i_rst_n(rst_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_data),
		.o_value(data_s)
	);

	// comparator output is asynchronous to our clock
	tthc_sync3 #(.W(1)) u_sync_cp (
		.i_clock(i_clock),
		.i_rst_n(rst_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_call_progress_square),
		.o_value(cp_square_s)
	);

	// ==========================================================
	// next state
	always_comb begin
		logic wr_done;
		logic rd_start;
		logic rd_end;
		logic tx_start;
		logic burst_on;
		logic cp_mode;
		logic pull_low;
		logic [`TTHC_CNT_W-1:0] len;
		logic [`TTHC_DATA_W-1:0] status;
		wr_done = 1'b0;
		rd_start = 1'b0;
		rd_end = 1'b0;
		tx_start = 1'b0;
		burst_on = ~st.control_word_b[`TTHC_B_BURST_N];
		cp_mode = st.control_word_a[`TTHC_A_CALL_PROGRESS];
		pull_low = 1'b0;
		len = cp_mode ? BURST_CP_CYCLES : BURST_CYCLES;
		status = '0;
		next_st = st;
		next_st.bus_q = bus_s;
		next_st.data_q = data_s;

		// write commits on the strobe's trailing edge with data held during it
		wr_done = ~st.bus_q.cs_n & ~st.bus_q.wr_n & bus_s.wr_n;
		rd_start = ~bus_s.cs_n & ~bus_s.rd_n & (st.bus_q.rd_n | st.bus_q.cs_n);
		rd_end = st.rd_active & (bus_s.rd_n | bus_s.cs_n);

		if (wr_done) begin
			if (!st.bus_q.register_class_select) begin
				next_st.tx_code = st.data_q;
				tx_start = 1'b1;
			end else if (st.control_bank_select) begin
				next_st.control_word_b = st.data_q;
				next_st.control_bank_select = 1'b0;
			end else begin
				next_st.control_word_a = st.data_q;
				next_st.control_bank_select = st.data_q[`TTHC_A_BANK_SEL];
			end
		end

		// ----------------------------------------------------------
		// burst and pause sequencer
		unique case (st.phase)
			TTHC_IDLE: begin
				next_st.count = st.count;
			end
			TTHC_BURST: begin
				if (st.count == '0) begin
					next_st.phase = TTHC_PAUSE;
					next_st.count = len - `TTHC_CNT_W'(1);
				end else begin
					next_st.count = st.count - `TTHC_CNT_W'(1);
				end
			end
			TTHC_PAUSE: begin
				if (st.count == '0) begin
					next_st.phase = TTHC_IDLE;
					// empty is raised below, where a same-cycle write can veto it
				end else begin
					next_st.count = st.count - `TTHC_CNT_W'(1);
				end
			end
		endcase
		// a new digit restarts the burst; the host is expected to wait for empty
		if (tx_start && burst_on) begin
			next_st.phase = TTHC_BURST;
			next_st.count = len - `TTHC_CNT_W'(1);
		end
		if (!burst_on) begin
			next_st.phase = TTHC_IDLE;
		end

		// ----------------------------------------------------------
		// status read: drive on leading edge, clear on trailing edge
		status[`TTHC_S_IRQ] = st.tx_empty | st.rx_full;
		status[`TTHC_S_TX_EMPTY] = st.tx_empty;
		status[`TTHC_S_RX_FULL] = st.rx_full;
		status[`TTHC_S_STEER] = st.steer;
		if (rd_start) begin
			next_st.rd_active = 1'b1;
			next_st.rd_status = bus_s.register_class_select;
			next_st.dout_oe_n = 1'b0;
			next_st.dout = bus_s.register_class_select ? status : st.rx_code;
		end
		// clearing only at the end of the read drops a flag raised while a slow read is in progress
		if (rd_end) begin
			next_st.rd_active = 1'b0;
			next_st.dout_oe_n = 1'b1;
			if (st.rd_status) begin
				next_st.tx_empty = 1'b0;
				next_st.rx_full = 1'b0;
			end
		end
		// events override a clear in the same cycle
		// a write that lands as the pause ends starts a new burst instead
		if ((st.phase == TTHC_PAUSE) && (st.count == '0) && burst_on && !tx_start) begin
			next_st.tx_empty = 1'b1;
		end
		if (!burst_on) begin
			next_st.tx_empty = 1'b0;
		end
		if (i_rx_digit_valid && !cp_mode) begin
			next_st.rx_code = i_rx_digit_code;
			next_st.rx_full = 1'b1;
		end
		next_st.steer = ~i_delayed_steer;

		// ----------------------------------------------------------
		// generator and receiver controls
		// the enable lags the phase by one cycle, so burst and pause stay equal
		next_st.tone_on = st.control_word_a[`TTHC_A_TONE_OUT]
			& (~burst_on | (st.phase == TTHC_BURST));
		// column only matters with single tone; the generator combines them
		next_st.single_tone = st.control_word_b[`TTHC_B_SINGLE];
		next_st.column_group = st.control_word_b[`TTHC_B_COLUMN];
		next_st.rx_enable = ~cp_mode;

		// ----------------------------------------------------------
		// shared pin, only ever pulled low
		if (cp_mode) begin
			pull_low = st.control_word_a[`TTHC_A_IRQ_EN] & ~cp_square_s;
		end else if (st.control_word_b[`TTHC_B_TEST]) begin
			// test mode ignores the interrupt enable so steering can be probed
			pull_low = ~st.steer;
		end else begin
			pull_low = st.control_word_a[`TTHC_A_IRQ_EN] & (st.tx_empty | st.rx_full);
		end
		next_st.irq_oe_n = ~pull_low;
	end

	// ==========================================================
	// state register
	// the counter is sized for the doubled call progress length
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{
				control_word_a: `TTHC_CTRL_A_RST,
				control_word_b: `TTHC_CTRL_B_RST,
				tx_code: `TTHC_DIGIT_RST,
				rx_code: `TTHC_DIGIT_RST,
				control_bank_select: 1'b0,
				tx_empty: 1'b0,
				rx_full: 1'b0,
				steer: 1'b1,
				phase: TTHC_IDLE,
				count: '0,
				bus_q: '1,
				data_q: '0,
				rd_active: 1'b0,
				rd_status: 1'b0,
				dout: '0,
				dout_oe_n: 1'b1,
				irq_oe_n: 1'b1,
				tone_on: 1'b0,
				single_tone: 1'b0,
				column_group: 1'b0,
				rx_enable: 1'b1
			};
		end else if (i_clk_en) begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs straight from state
	// the pin's output level is a constant low flop; only its enable moves
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_interrupt_tone_pin <= 1'b0;
		end else if (i_clk_en) begin
			o_interrupt_tone_pin <= 1'b0;
		end
	end

	assign o_data = st.dout;
	assign o_data_oe_n = st.dout_oe_n;
	assign o_interrupt_tone_pin_oe_n = st.irq_oe_n;
	assign o_rx_enable = st.rx_enable;
	assign o_tone_code = st.tx_code;
	assign o_tone_on = st.tone_on;
	assign o_single_tone = st.single_tone;
	assign o_column_group = st.column_group;
endmodule

// ==== pkg/tthc_defs.svh ====
// constants for the tone transceiver host port: field positions, reset values, timing
// assumes it is included by bare name from the package and the design files
`ifndef TTHC_DEFS_SVH
`define TTHC_DEFS_SVH

// ==========================================================
// clock and burst timing
`define TTHC_CLK_KHZ 125000
`define TTHC_BURST_TIME_MS 51
`define TTHC_BURST_CP_TIME_MS 102
`define TTHC_BURST_CYCLES (`TTHC_BURST_TIME_MS * `TTHC_CLK_KHZ)
`define TTHC_BURST_CP_CYCLES (`TTHC_BURST_CP_TIME_MS * `TTHC_CLK_KHZ)
`define TTHC_CNT_W 24

// ==========================================================
// data widths
`define TTHC_DATA_W 4
`define TTHC_PIN_W 4

// ==========================================================
// control word a fields
`define TTHC_A_TONE_OUT 0
`define TTHC_A_CALL_PROGRESS 1
`define TTHC_A_IRQ_EN 2
`define TTHC_A_BANK_SEL 3

// ==========================================================
// control word b fields
`define TTHC_B_BURST_N 0
`define TTHC_B_TEST 1
`define TTHC_B_SINGLE 2
`define TTHC_B_COLUMN 3

// ==========================================================
// status fields
`define TTHC_S_IRQ 0
`define TTHC_S_TX_EMPTY 1
`define TTHC_S_RX_FULL 2
`define TTHC_S_STEER 3

// ==========================================================
// reset values
`define TTHC_CTRL_A_RST 4'h0
`define TTHC_CTRL_B_RST 4'h0
`define TTHC_DIGIT_RST 4'h0

`endif

// ==== pkg/tthc_pkg.sv ====
// types shared by the tone transceiver host port
// assumes tthc_defs.svh is on the include path
package tthc_pkg;
	`include "tthc_defs.svh"

	// ==========================================================
	// synchronised host pins
	typedef struct packed {
		logic cs_n;
		logic register_class_select;
		logic wr_n;
		logic rd_n;
	} tthc_bus_s;

	typedef enum logic [1:0] {
		TTHC_IDLE,
		TTHC_BURST,
		TTHC_PAUSE
	} tthc_phase_e;

	// ==========================================================
	// all state of the host port
	typedef struct packed {
		logic [`TTHC_DATA_W-1:0] control_word_a;
		logic [`TTHC_DATA_W-1:0] control_word_b;
		logic [`TTHC_DATA_W-1:0] tx_code;
		logic [`TTHC_DATA_W-1:0] rx_code;
		logic control_bank_select;
		logic tx_empty;
		logic rx_full;
		logic steer;
		tthc_phase_e phase;
		logic [`TTHC_CNT_W-1:0] count;
		tthc_bus_s bus_q;
		logic [`TTHC_DATA_W-1:0] data_q;
		logic rd_active;
		logic rd_status;
		logic [`TTHC_DATA_W-1:0] dout;
		logic dout_oe_n;
		logic irq_oe_n;
		logic tone_on;
		logic single_tone;
		logic column_group;
		logic rx_enable;
	} tthc_state_s;
endpackage

// ==== core/tthc_sync3.sv ====
// three-stage synchroniser for pin inputs with agreement filter
// assumes one clock; the value moves on only when stages two and three agree
`timescale 1ns/100ps
module tthc_sync3 #(
	parameter int W = 1
) (
	// clock, reset and enable
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// pins in, filtered value out
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_value
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// ==========================================================
	// stage1 feeds stage2 only
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= '1;
			stage2 <= '1;
			stage3 <= '1;
			o_value <= '1;
		end else if (i_clk_en) begin
			stage1 <= i_pin;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					o_value[i] <= stage3[i];
				end
			end
		end
	end
endmodule

// ==== sim/tthc_host_ctrl_asserts.sv ====
// concurrent checks on the pins of the tone transceiver host port
// assumes it is bound to tthc_host_ctrl and sees only its ports
`timescale 1ns/100ps
module tthc_hc_chk (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// host strobes
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	// outputs watched
	input wire logic o_data_oe_n,
	input wire logic o_interrupt_tone_pin,
	input wire logic o_interrupt_tone_pin_oe_n,
	input wire logic o_rx_enable,
	input wire logic [3:0] o_tone_code,
	input wire logic o_tone_on,
	input wire logic o_single_tone,
	input wire logic o_column_group
);
	// cycles since the write strobe pin was last low, saturating
	logic [3:0] wr_age;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			wr_age <= 4'hf;
		else if (!i_wr_n)
			wr_age <= 4'h0;
		else if (wr_age != 4'hf)
			wr_age <= wr_age + 4'h1;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ==========================================================
	// assertions
	a_pin_never_high: assert property (o_interrupt_tone_pin == 1'b0)
		else $error("interrupt pin driven high");
	a_read_answer: assert property ($fell(i_rd_n) && !i_cs_n |-> ##[3:7] !o_data_oe_n)
		else $error("read data late");
	a_read_release: assert property ($rose(i_rd_n) |-> ##[2:7] o_data_oe_n)
		else $error("data bus not released");
	a_drive_cause: assert property ($fell(o_data_oe_n) |-> $past(!i_rd_n && !i_cs_n, 2))
		else $error("data bus driven without read");
	a_quiet_on_write: assert property (!i_wr_n |-> o_data_oe_n)
		else $error("data bus driven during write");
	a_code_by_write: assert property ($changed(o_tone_code) |-> wr_age < 4'hc)
		else $error("tone code moved without write");
	a_mode_by_write: assert property ($changed({o_single_tone, o_column_group}) |-> wr_age < 4'hc)
		else $error("tone mode moved without write");
	a_rx_by_write: assert property ($changed(o_rx_enable) |-> wr_age < 4'hc)
		else $error("receive enable moved without write");
	c_read: cover property ($fell(o_data_oe_n));
	c_tone: cover property ($rose(o_tone_on));
	c_pin: cover property ($fell(o_interrupt_tone_pin_oe_n));
endmodule

// ==== sim/tthc_host_model.sv ====
// microcontroller model driving the transceiver bus pins
// assumes tasks are called from one process at a falling clock edge
`timescale 1ns/100ps
module tthc_host_model (
	// clock
	input wire logic i_clock,
	// bus pins
	output logic o_cs_n = 1'b1,
	output logic o_rs = 1'b1,
	output logic o_wr_n = 1'b1,
	output logic o_rd_n = 1'b1,
	output logic [3:0] o_data = 4'h5,
	input wire logic [3:0] i_data
);
	task automatic wt(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	// strobes are held far past the three-flop pin filter
	task automatic bus_wr(input logic rs, input logic [3:0] d);
		o_cs_n = 1'b0;
		o_rs = rs;
		o_data = d;
		wt(2);
		o_wr_n = 1'b0;
		wt(8);
		o_wr_n = 1'b1;
		wt(7);
		o_cs_n = 1'b1;
		// a released bus shows no stale value
		o_data = ~d;
		wt(8);
	endtask
	task automatic bus_rd(input logic rs, output logic [3:0] d);
		o_cs_n = 1'b0;
		o_rs = rs;
		o_rd_n = 1'b0;
		wt(9);
		d = i_data;
		o_rd_n = 1'b1;
		o_cs_n = 1'b1;
		wt(9);
	endtask
endmodule

// ==== sim/tthc_host_ctrl_tb.sv ====
// self-checking bench for the tone transceiver host port
// assumes the host model drives the bus and the bench drives the receiver side
`timescale 1ns/100ps
module tthc_host_ctrl_tb;
	localparam int BC = 20;
	logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, steer = 1'b0, sq = 1'b1;
	logic txe = 1'b0, rxf = 1'b0, cen = 1'b1;
	logic [3:0] rxc = 4'h0, hd, dd, bus, rdv, tc;
	logic cs_n, rs, wr_n, rd_n, doe_n, poe_n, pin, ton, st, cg, rxe;
	int seed = 32'h2199, miscompares = 0, cmp_count = 0, cyc = 0, run = 0, last = 0;
	int rxq[$];
	always #4 clk = ~clk;
	assign bus = doe_n ? hd : dd;
	tthc_host_model u_tthc_host_model (.i_clock(clk), .o_cs_n(cs_n), .o_rs(rs),
		.o_wr_n(wr_n), .o_rd_n(rd_n), .o_data(hd), .i_data(bus));
	tthc_host_ctrl #(.BURST_CYCLES(24'(BC)), .BURST_CP_CYCLES(24'(2 * BC))) u_tthc_host_ctrl (
		.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(cen), .i_cs_n(cs_n),
		.i_register_class_select(rs), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_data(bus),
		.o_data(dd), .o_data_oe_n(doe_n), .i_interrupt_tone_pin(poe_n ? 1'b1 : pin),
		.o_interrupt_tone_pin(pin), .o_interrupt_tone_pin_oe_n(poe_n),
		.i_rx_digit_valid(vld), .i_rx_digit_code(rxc), .i_delayed_steer(steer),
		.i_call_progress_square(sq), .o_rx_enable(rxe), .o_tone_code(tc), .o_tone_on(ton),
		.o_single_tone(st), .o_column_group(cg));
	task automatic check(input string n, input logic [3:0] s, input logic [3:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========================================================
	// bus helpers and the reference model
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wa(input logic [3:0] v);
		u_tthc_host_model.bus_wr(1'b1, v);
	endtask
	task automatic wb(input logic [3:0] v);
		wa(4'h8);
		wa(v);
	endtask
	task automatic stat();
		u_tthc_host_model.bus_rd(1'b1, rdv);
		check("status", rdv, {~steer, rxf, txe, rxf | txe});
		txe = 0;
		rxf = 0;
	endtask
	task automatic pulse(input logic [3:0] c);
		vld = 1;
		rxc = c;
		wt(1);
		vld = 0;
		wt(4);
	endtask
	// burst lengths are measured from the generator enable itself
	always @(posedge clk) begin
		cyc++;
		if (ton)
			run++;
		else if (run > 0) begin
			last = run;
			run = 0;
		end
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		logic [3:0] tx, rxl;
		wt(20);
		check("rst_out", {ton, rxe, doe_n, poe_n}, 4'h7);
		check("rst_code", tc, 4'h0);
		check("rst_mode", {2'b00, st, cg}, 4'h0);
		rst_n = 1;
		wt(10);
		wa(4'h0);
		wb(4'h1);
		stat();
		for (int k = 0; k < 4; k++) begin
			wb({k[1:0], 2'b01});
			check("single", 4'(st), 4'(k[0]));
			check("column", 4'(cg), 4'(k[1]));
		end
		for (int k = 1; k >= 0; k--) begin
			wa(4'(k));
			check("tone_on", 4'(ton), 4'(k));
		end
		$display("modes done");
		wb(4'h0);
		wa(4'h5);
		tx = 4'($random(seed));
		u_tthc_host_model.bus_wr(1'b0, tx);
		check("code", tc, tx);
		wt(2 * BC + 10);
		txe = 1;
		check("irq", 4'(poe_n), 4'h0);
		stat();
		check("burst", 4'(last >= BC - 1 && last <= BC + 1), 4'h1);
		check("irq", 4'(poe_n), 4'h1);
		wa(4'h3);
		check("rx_en", 4'(rxe), 4'h0);
		u_tthc_host_model.bus_wr(1'b0, 4'($random(seed)));
		pulse(4'($random(seed)));
		wt(4 * BC + 10);
		txe = 1;
		stat();
		check("cp_burst", 4'(last >= 2 * BC - 2 && last <= 2 * BC + 2), 4'h1);
		wa(4'h6);
		sq = 0;
		wt(8);
		check("cp_pin", 4'(poe_n), 4'h0);
		sq = 1;
		wt(8);
		check("cp_pin", 4'(poe_n), 4'h1);
		$display("burst done");
		wb(4'h1);
		wa(4'h4);
		check("rx_en", 4'(rxe), 4'h1);
		for (int k = 0; k < 2; k++) begin
			rxq.push_back($random(seed) & 15);
			pulse(4'(rxq[0]));
			rxf = 1;
			check("irq", 4'(poe_n), 4'h0);
			u_tthc_host_model.bus_rd(1'b0, rdv);
			rxl = 4'(rxq.pop_front());
			check("rx_code", rdv, rxl);
			steer = k[0];
			wt(4);
			stat();
			check("irq", 4'(poe_n), 4'h1);
		end
		cen = 1'b0;
		pulse(~rxl);
		cen = 1'b1;
		u_tthc_host_model.bus_rd(1'b0, rdv);
		check("frozen", rdv, rxl);
		stat();
		$display("receive done");
		wb(4'h3);
		wa(4'h0);
		wt(4);
		check("test_pin", 4'(poe_n), 4'h0);
		steer = 0;
		wt(4);
		check("test_pin", 4'(poe_n), 4'h1);
		$display("test mode done");
		give_verdict();
	end
endmodule
bind tthc_host_ctrl tthc_hc_chk u_tthc_hc_chk (.i_clock, .i_rst_n, .i_cs_n, .i_wr_n,
	.i_rd_n, .o_data_oe_n, .o_interrupt_tone_pin, .o_interrupt_tone_pin_oe_n,
	.o_rx_enable, .o_tone_code, .o_tone_on, .o_single_tone, .o_column_group);
